// ### design/reload_timer.sv
// two-channel reload timer with axi4-lite register access
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module reload_timer (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic addr_line_in,
   output logic shared_addr_wave_pin,
   output logic timer_irq
);
   // =====================================================
   // state
   typedef struct packed {
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [7:0] w_data;
      logic w_en;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic tf0;
      logic tf1;
      logic armed0;
      logic armed1;
      logic ie0;
      logic ie1;
      logic [1:0] oc;
      logic ce0;
      logic ce1;
      logic wave;
      logic pin;
      logic irq;
      logic awready;
      logic wready;
      logic arready;
   } top_s;
   top_s s_r;
   top_s s_nxt;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a <= reload_timer_pkg::OFS_RLD1_HI) && (a[1:0] == 2'b00);
   endfunction

   // one strobe per register, shared by the write and the read decode
   function automatic logic sel(
      input logic go,
      input logic [7:0] a,
      input logic [7:0] ofs
   );
      sel = go && (a == ofs);
   endfunction

   logic tick;
   logic wr_go;
   logic rd_go;
   logic [7:0] waddr;
   logic wr_ok;
   logic wr_ctrl;
   logic wr_cnt_lo0;
   logic wr_cnt_hi0;
   logic wr_rld_lo0;
   logic wr_rld_hi0;
   logic wr_cnt_lo1;
   logic wr_cnt_hi1;
   logic wr_rld_lo1;
   logic wr_rld_hi1;
   logic [15:0] cnt0;
   logic [15:0] cnt1;
   logic [15:0] rld0;
   logic [15:0] rld1;
   logic [7:0] hold0;
   logic [7:0] hold1;
   logic to0;
   logic to1;
   logic rd_lo0;
   logic rd_lo1;
   logic rd_hi0;
   logic rd_hi1;
   logic rd_rld_lo0;
   logic rd_rld_hi0;
   logic rd_rld_lo1;
   logic rd_rld_hi1;
   logic rd_ctrl;
   logic [7:0] ctrl_view;

   // =====================================================
   // address decode
   assign wr_go = s_r.aw_got && s_r.w_got && !s_r.bvalid;
   assign rd_go = s_axi_arvalid && !s_r.rvalid;
   assign waddr = s_r.aw_addr;
   // a cleared byte strobe still answers, but changes nothing
   assign wr_ok = wr_go && s_r.w_en;
   assign wr_ctrl = sel(wr_ok, waddr, reload_timer_pkg::OFS_CTRL);
   assign wr_cnt_lo0 = sel(wr_ok, waddr, reload_timer_pkg::OFS_CNT0_LO);
   assign wr_cnt_hi0 = sel(wr_ok, waddr, reload_timer_pkg::OFS_CNT0_HI);
   assign wr_rld_lo0 = sel(wr_ok, waddr, reload_timer_pkg::OFS_RLD0_LO);
   assign wr_rld_hi0 = sel(wr_ok, waddr, reload_timer_pkg::OFS_RLD0_HI);
   assign wr_cnt_lo1 = sel(wr_ok, waddr, reload_timer_pkg::OFS_CNT1_LO);
   assign wr_cnt_hi1 = sel(wr_ok, waddr, reload_timer_pkg::OFS_CNT1_HI);
   assign wr_rld_lo1 = sel(wr_ok, waddr, reload_timer_pkg::OFS_RLD1_LO);
   assign wr_rld_hi1 = sel(wr_ok, waddr, reload_timer_pkg::OFS_RLD1_HI);
   assign rd_ctrl = sel(rd_go, s_axi_araddr,
      reload_timer_pkg::OFS_CTRL);
   assign rd_lo0 = sel(rd_go, s_axi_araddr,
      reload_timer_pkg::OFS_CNT0_LO);
   assign rd_hi0 = sel(rd_go, s_axi_araddr,
      reload_timer_pkg::OFS_CNT0_HI);
   assign rd_lo1 = sel(rd_go, s_axi_araddr,
      reload_timer_pkg::OFS_CNT1_LO);
   assign rd_hi1 = sel(rd_go, s_axi_araddr,
      reload_timer_pkg::OFS_CNT1_HI);
   assign rd_rld_lo0 = sel(rd_go, s_axi_araddr,
      reload_timer_pkg::OFS_RLD0_LO);
   assign rd_rld_hi0 = sel(rd_go, s_axi_araddr,
      reload_timer_pkg::OFS_RLD0_HI);
   assign rd_rld_lo1 = sel(rd_go, s_axi_araddr,
      reload_timer_pkg::OFS_RLD1_LO);
   assign rd_rld_hi1 = sel(rd_go, s_axi_araddr,
      reload_timer_pkg::OFS_RLD1_HI);

   // =====================================================
   // helpers
   tick_divider u_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick)
   );

   timer_channel u_ch0 (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick),
      .enable(s_r.ce0),
      .wr_cnt_lo(wr_cnt_lo0),
      .wr_cnt_hi(wr_cnt_hi0),
      .wr_rld_lo(wr_rld_lo0),
      .wr_rld_hi(wr_rld_hi0),
      .wdata(s_r.w_data),
      .rd_lo(rd_lo0),
      .count(cnt0),
      .reload(rld0),
      .held_hi(hold0),
      .timeout(to0)
   );

   timer_channel u_ch1 (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick),
      .enable(s_r.ce1),
      .wr_cnt_lo(wr_cnt_lo1),
      .wr_cnt_hi(wr_cnt_hi1),
      .wr_rld_lo(wr_rld_lo1),
      .wr_rld_hi(wr_rld_hi1),
      .wdata(s_r.w_data),
      .rd_lo(rd_lo1),
      .count(cnt1),
      .reload(rld1),
      .held_hi(hold1),
      .timeout(to1)
   );

   assign ctrl_view = {s_r.tf1, s_r.tf0, s_r.ie1, s_r.ie0, s_r.oc,
      s_r.ce1, s_r.ce0};

   // =====================================================
   // next state
   always_comb begin
      s_nxt = s_r;
      // write channel capture, either order
      if (s_axi_awvalid && !s_r.aw_got) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_r.w_got) begin
         s_nxt.w_got = 1'b1;
         s_nxt.w_data = s_axi_wdata[7:0];
         s_nxt.w_en = s_axi_wstrb[0];
      end
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      if (wr_go) begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = mapped(waddr) ? reload_timer_pkg::RESP_OKAY
            : reload_timer_pkg::RESP_SLVERR;
         if (wr_ctrl) begin
            // flag bits are read only
            s_nxt.ie1 = s_r.w_data[reload_timer_pkg::BIT_IE1];
            s_nxt.ie0 = s_r.w_data[reload_timer_pkg::BIT_IE0];
            s_nxt.oc = s_r.w_data[reload_timer_pkg::BIT_OC_HI:
               reload_timer_pkg::BIT_OC_LO];
            s_nxt.ce1 = s_r.w_data[reload_timer_pkg::BIT_CE1];
            s_nxt.ce0 = s_r.w_data[reload_timer_pkg::BIT_CE0];
         end
      end
      // read channel
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (rd_go) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = mapped(s_axi_araddr) ? reload_timer_pkg::RESP_OKAY
            : reload_timer_pkg::RESP_SLVERR;
         if (rd_lo0) begin
            s_nxt.rdata = {24'h00_0000, cnt0[7:0]};
         end else if (rd_hi0) begin
            s_nxt.rdata = {24'h00_0000, hold0};
         end else if (rd_rld_lo0) begin
            s_nxt.rdata = {24'h00_0000, rld0[7:0]};
         end else if (rd_rld_hi0) begin
            s_nxt.rdata = {24'h00_0000, rld0[15:8]};
         end else if (rd_ctrl) begin
            s_nxt.rdata = {24'h00_0000, ctrl_view};
         end else if (rd_lo1) begin
            s_nxt.rdata = {24'h00_0000, cnt1[7:0]};
         end else if (rd_hi1) begin
            s_nxt.rdata = {24'h00_0000, hold1};
         end else if (rd_rld_lo1) begin
            s_nxt.rdata = {24'h00_0000, rld1[7:0]};
         end else if (rd_rld_hi1) begin
            s_nxt.rdata = {24'h00_0000, rld1[15:8]};
         end else begin
            s_nxt.rdata = 32'h0000_0000;
         end
      end
      // flag clear needs a control read first; set wins over clear
      if (rd_ctrl) begin
         s_nxt.armed0 = s_r.tf0;
         s_nxt.armed1 = s_r.tf1;
      end
      if (s_r.armed0 && (rd_lo0 || rd_hi0)) begin
         s_nxt.tf0 = 1'b0;
         s_nxt.armed0 = 1'b0;
      end
      if (s_r.armed1 && (rd_lo1 || rd_hi1)) begin
         s_nxt.tf1 = 1'b0;
         s_nxt.armed1 = 1'b0;
      end
      if (to0) begin
         s_nxt.tf0 = 1'b1;
      end
      if (to1) begin
         s_nxt.tf1 = 1'b1;
      end
      // wave toggles track channel 1 timeout parity, starting high
      if (to1) begin
         case (reload_timer_pkg::out_mode_e'(s_r.oc))
            reload_timer_pkg::OUT_TOGGLE: s_nxt.wave = !s_r.wave;
            reload_timer_pkg::OUT_LOW: s_nxt.wave = 1'b0;
            reload_timer_pkg::OUT_HIGH: s_nxt.wave = 1'b1;
            // address mode still counts parity
            default: s_nxt.wave = !s_r.wave;
         endcase
      end
      // pin is the address line when output is off
      s_nxt.pin = (s_nxt.oc == 2'b00) ? addr_line_in : s_nxt.wave;
      s_nxt.irq = (s_nxt.tf0 && s_nxt.ie0)
         || (s_nxt.tf1 && s_nxt.ie1);
      // readies are registered too, so every port leaves a flip-flop
      s_nxt.awready = !s_nxt.aw_got;
      s_nxt.wready = !s_nxt.w_got;
      s_nxt.arready = !s_nxt.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
         s_r.wave <= 1'b1;
         s_r.oc <= reload_timer_pkg::CTRL_RESET[1:0];
         s_r.ce0 <= 1'b0;
         s_r.ce1 <= 1'b0;
         s_r.awready <= 1'b1;
         s_r.wready <= 1'b1;
         s_r.arready <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign s_axi_awready = s_r.awready;
   assign s_axi_wready = s_r.wready;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_arready = s_r.arready;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;
   assign shared_addr_wave_pin = s_r.pin;
   assign timer_irq = s_r.irq;
endmodule

// ### design/tick_divider.sv
// divide-by-twenty count tick
`timescale 1ns/1ps
module tick_divider (
   input wire logic aclk,
   input wire logic aresetn,
   output logic tick
);
   typedef struct packed {
      logic [4:0] cnt;
      logic tick;
   } div_s;
   div_s s_r;
   div_s s_nxt;
   always_comb begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      // one pulse every twenty clocks
      if (s_r.cnt == reload_timer_pkg::TICK_LAST) begin
         s_nxt.cnt = 5'h00;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.cnt = s_r.cnt + 5'h01;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign tick = s_r.tick;
endmodule

// ### design/timer_channel.sv
// one 16-bit down counter with reload and latched high byte
`timescale 1ns/1ps
module timer_channel (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tick,
   input wire logic enable,
   input wire logic wr_cnt_lo,
   input wire logic wr_cnt_hi,
   input wire logic wr_rld_lo,
   input wire logic wr_rld_hi,
   input wire logic [7:0] wdata,
   input wire logic rd_lo,
   output logic [15:0] count,
   output logic [15:0] reload,
   output logic [7:0] held_hi,
   output logic timeout
);
   typedef struct packed {
      logic [15:0] cnt;
      logic [15:0] rld;
      logic [7:0] hold;
   } ch_s;
   ch_s s_r;
   ch_s s_nxt;
   logic hit;
   always_comb begin
      s_nxt = s_r;
      hit = 1'b0;
      // decrement only while enabled, reload instead of stepping from one to zero
      if (enable && tick) begin
         if (s_r.cnt == 16'h0001 || s_r.cnt == 16'h0000) begin
            s_nxt.cnt = s_r.rld;
            hit = 1'b1;
         end else begin
            s_nxt.cnt = s_r.cnt - 16'h0001;
         end
      end
      // writes are meant for a stopped counter
      if (wr_cnt_lo) begin
         s_nxt.cnt[7:0] = wdata;
      end
      if (wr_cnt_hi) begin
         s_nxt.cnt[15:8] = wdata;
      end
      if (wr_rld_lo) begin
         s_nxt.rld[7:0] = wdata;
      end
      if (wr_rld_hi) begin
         s_nxt.rld[15:8] = wdata;
      end
      if (rd_lo) begin
         s_nxt.hold = s_r.cnt[15:8];
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r.cnt <= reload_timer_pkg::CNT_RESET;
         s_r.rld <= reload_timer_pkg::CNT_RESET;
         s_r.hold <= reload_timer_pkg::CNT_RESET[15:8];
      end else begin
         s_r <= s_nxt;
      end
   end
   assign count = s_r.cnt;
   assign reload = s_r.rld;
   assign held_hi = s_r.hold;
   assign timeout = hit;
endmodule

// ### pkg/reload_timer_pkg.sv
// constants for the two-channel reload timer
package reload_timer_pkg;
   // =====================================================
   // register byte addresses
   localparam logic [7:0] OFS_CNT0_LO = 8'h00;
   localparam logic [7:0] OFS_CNT0_HI = 8'h04;
   localparam logic [7:0] OFS_RLD0_LO = 8'h08;
   localparam logic [7:0] OFS_RLD0_HI = 8'h0c;
   localparam logic [7:0] OFS_CTRL = 8'h10;
   localparam logic [7:0] OFS_CNT1_LO = 8'h14;
   localparam logic [7:0] OFS_CNT1_HI = 8'h18;
   localparam logic [7:0] OFS_RLD1_LO = 8'h1c;
   localparam logic [7:0] OFS_RLD1_HI = 8'h20;
   // =====================================================
   // control field positions
   localparam int BIT_TF1 = 7;
   localparam int BIT_TF0 = 6;
   localparam int BIT_IE1 = 5;
   localparam int BIT_IE0 = 4;
   localparam int BIT_OC_HI = 3;
   localparam int BIT_OC_LO = 2;
   localparam int BIT_CE1 = 1;
   localparam int BIT_CE0 = 0;
   // =====================================================
   // reset values and timing
   localparam logic [15:0] CNT_RESET = 16'hffff;
   localparam logic [5:0] CTRL_RESET = 6'h00;
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_DIV = 20;
   localparam logic [4:0] TICK_LAST = 5'(TICK_DIV - 1);
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {
      OUT_ADDR, OUT_TOGGLE, OUT_LOW, OUT_HIGH
   } out_mode_e;
endpackage

// ### tb/reload_timer_chk.sv
// port assertions for the reload timer
`timescale 1ns/1ps
module reload_timer_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic addr_line_in,
   input wire logic shared_addr_wave_pin,
   input wire logic timer_irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ====
   // reset outcome: these look through reset, so no disable
   irq_reset_a:
      assert property (disable iff (1'b0) !aresetn |=> !timer_irq)
      else $error("irq high after reset");
   pin_reset_a:
      assert property (disable iff (1'b0) !aresetn ##1 aresetn
         |=> shared_addr_wave_pin == $past(addr_line_in))
      else $error("pin not on address line after reset");
   // ====
   // register bus
   read_answer_a:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   write_answer_a:
      assert property (s_axi_awvalid && s_axi_awready
         |-> ##[1:4] s_axi_bvalid)
      else $error("write not answered");
   read_hold_a:
      assert property (s_axi_rvalid && !s_axi_rready
         |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped early");
   write_hold_a:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped early");
   bad_addr_a:
      assert property (s_axi_arvalid && s_axi_arready
         && (s_axi_araddr[1:0] != 2'b00 || s_axi_araddr > 8'h20)
         |=> s_axi_rresp == reload_timer_pkg::RESP_SLVERR
         && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   upper_zero_a:
      assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
endmodule
bind reload_timer reload_timer_chk u_reload_timer_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .addr_line_in(addr_line_in),
   .shared_addr_wave_pin(shared_addr_wave_pin), .timer_irq(timer_irq));

// ### tb/reload_timer_tb.sv
// self-checking bench for the reload timer
`timescale 1ns/1ps
module reload_timer_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, addr_in = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic awready, wready, bvalid, arready, rvalid, pin, irq;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d;
   int failures = 0;
   int comparisons = 0;
   always #5 aclk = ~aclk;
   reload_timer u_reload_timer (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .addr_line_in(addr_in),
      .shared_addr_wave_pin(pin), .timer_irq(irq));
   // ====
   // bus and compare tasks
   task automatic test_done();
      if (failures == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic limit(input int n);
      if (n >= 60) begin
         failures++;
         test_done();
      end
   endtask
   // handshakes are judged at the negedge, where registered readies are
   // settled, and released right after the following rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      int n;
      logic aw, w, b;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h00_0000, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(negedge aclk);
         aw = awvalid && awready;
         w = wvalid && wready;
         b = bvalid;
         r = bresp;
         @(posedge aclk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         n++;
      end while (!b && n < 60);
      bready <= 1'b0;
      limit(n);
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      logic ar, v;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(negedge aclk);
         ar = arvalid && arready;
         v = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ar) arvalid <= 1'b0;
         n++;
      end while (!v && n < 60);
      rready <= 1'b0;
      limit(n);
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, e);
      rd(a);
      chk(nm, {24'h00_0000, e}, d);
   endtask
   task automatic wait_irq(input logic v);
      int n;
      n = 0;
      do begin
         @(negedge aclk);
         n++;
      end while (irq !== v && n < 300);
      limit(n / 5);
   endtask
   task automatic pchk(input logic e);
      repeat (3) @(negedge aclk);
      chk("pin", {31'h0000_0000, e}, {31'h0000_0000, pin});
   endtask
   task automatic ichk(input logic e);
      repeat (3) @(negedge aclk);
      chk("irq", {31'h0000_0000, e}, {31'h0000_0000, irq});
   endtask
   // ====
   // scenarios
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rdc("cnt0 lo", 8'h00, 8'hff);
      rdc("rld1 hi", 8'h20, 8'hff);
      rdc("ctrl", 8'h10, 8'h00);
      @(posedge aclk);
      addr_in <= 1'b1;
      pchk(1'b1);
      rd(8'h24);
      chk("bad read", {30'h0000_0000, reload_timer_pkg::RESP_SLVERR}, r);
      wr(8'h24, 8'h5a);
      chk("bad write", {30'h0000_0000, reload_timer_pkg::RESP_SLVERR}, r);
      wr(8'h00, 8'h34);
      wr(8'h04, 8'h12);
      rdc("cnt0 lo", 8'h00, 8'h34);
      wr(8'h04, 8'h56);
      rdc("cnt0 hi held", 8'h04, 8'h12);
      repeat (60) @(posedge aclk);
      rdc("cnt0 still", 8'h00, 8'h34);
      rdc("cnt0 hi", 8'h04, 8'h56);
      wr(8'h00, 8'h03);
      wr(8'h04, 8'h00);
      wr(8'h08, 8'h05);
      wr(8'h0c, 8'h00);
      wr(8'h10, 8'h11);
      wait_irq(1'b1);
      wr(8'h10, 8'h10);
      rd(8'h00);
      ichk(1'b1);
      rdc("ctrl flag0", 8'h10, 8'h50);
      rd(8'h04);
      ichk(1'b0);
      rdc("ctrl clear", 8'h10, 8'h10);
      wr(8'h10, 8'h01);
      repeat (130) @(posedge aclk);
      ichk(1'b0);
      rdc("ctrl masked", 8'h10, 8'h41);
      wr(8'h14, 8'h02);
      wr(8'h18, 8'h00);
      wr(8'h1c, 8'h02);
      wr(8'h20, 8'h00);
      wr(8'h10, 8'h24);
      pchk(1'b1);
      wr(8'h10, 8'h26);
      wait_irq(1'b1);
      pchk(1'b0);
      rd(8'h10);
      rd(8'h14);
      wait_irq(1'b0);
      wait_irq(1'b1);
      pchk(1'b1);
      // forced modes are judged after a timeout has surely passed
      wr(8'h10, 8'h2a);
      repeat (60) @(posedge aclk);
      pchk(1'b0);
      wr(8'h10, 8'h2e);
      repeat (60) @(posedge aclk);
      pchk(1'b1);
      wr(8'h10, 8'h20);
      @(posedge aclk);
      addr_in <= 1'b0;
      pchk(1'b0);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      ichk(1'b0);
      rdc("ctrl reset", 8'h10, 8'h00);
      rd(8'h14);
      rdc("cnt1 hi reset", 8'h18, 8'hff);
      test_done();
   end
endmodule
